// ### fnrc_pkg.sv
// constants, types and register map of the field node reset controller
// assumes a single 100 MHz clock shared by every user of this package
package fnrc_pkg;

  // clock rate
  localparam int CLK_MHZ = 100;

  // reset pin timing, in ns as printed, then in cycles
  localparam int RESET_REJECT_TIME_NS = 35000;   // low time that must not reset
  localparam int RESET_EXEC_TIME_NS   = 44000;   // latest hi-z after falling edge
  localparam int RESET_TRIG_TIME_NS   = 40000;   // chosen trigger point in between
  localparam int RESET_REJECT_CYC     = RESET_REJECT_TIME_NS * CLK_MHZ / 1000;
  localparam int RESET_EXEC_CYC       = RESET_EXEC_TIME_NS * CLK_MHZ / 1000;
  localparam int RESET_TRIG_CYC       = RESET_TRIG_TIME_NS * CLK_MHZ / 1000;

  // power-on pulse width bounds and chosen width
  localparam int POR_PULSE_MIN_NS = 4000;
  localparam int POR_PULSE_MAX_NS = 6000;
  localparam int POR_MIN_CYC      = (POR_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_MAX_CYC      = POR_PULSE_MAX_NS * CLK_MHZ / 1000;
  localparam int POR_PULSE_CYC    = (POR_MIN_CYC + POR_MAX_CYC) / 2;

  // initialization limits
  localparam int INIT_TIME_US  = 2000;   // after command or pin reset
  localparam int INIT2_TIME_MS = 30;     // after power-up
  localparam int INIT3_TIME_MS = 1000;   // after power-up, heavy supply load
  localparam int INIT_CYC      = INIT_TIME_US * CLK_MHZ;
  localparam int INIT2_CYC     = INIT2_TIME_MS * 1000 * CLK_MHZ;
  localparam int INIT3_CYC     = INIT3_TIME_MS * 1000 * CLK_MHZ;
  localparam int FAULT_CYC     = RESET_EXEC_CYC + INIT_CYC;

  // status flashing
  localparam int FLASH_FREQ_HZ  = 2;
  localparam int FLASH_HALF_CYC = CLK_MHZ * 1000000 / (2 * FLASH_FREQ_HZ);

  // misc
  localparam int         RESET_HOLD_CYC = 2;      // chip reset length on logic reset
  localparam int         TMR_W          = 27;     // fits the longest init limit
  localparam logic [3:0] OUT_RESET_VAL  = 4'hF;

  // register byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_MASK  = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;

  // control fields and reset values
  localparam int         CTRL_WDOG_EN_BIT = 0;
  localparam int         CTRL_BIGCAP_BIT  = 1;
  localparam logic [1:0] CTRL_RESET_VAL   = 2'h0;
  localparam logic [7:0] MASK_RESET_VAL   = 8'h00;

  // operating modes
  typedef enum logic [1:0] {
    MODE_SLAVE    = 2'b00,
    MODE_MASTER   = 2'b01,
    MODE_REPEATER = 2'b10,
    MODE_MONITOR  = 2'b11
  } fnrc_mode_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_RST  = 2'b01,
    ST_INIT = 2'b10,
    ST_RUN  = 2'b11
  } fnrc_state_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fnrc_bus_t;

  // event layout, shared by status and mask registers
  typedef struct packed {
    logic fault;
    logic refused;
    logic por;
    logic illegal;
    logic wdog;
    logic bcast;
    logic cmd;
    logic ext;
  } fnrc_evt_t;

endpackage

// ### fnrc_pin_timer.sv
// low-time measurement of the external active-low reset pin
// assumes the pin is already synchronous to clk
module fnrc_pin_timer #(
  parameter int FAULT_CYC = fnrc_pkg::FAULT_CYC
)(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ext_reset_n,
  input  wire logic slave_mode,
  output logic      trig,
  output logic      fault
);

  localparam int CW = $clog2(FAULT_CYC + 1);

  logic [CW-1:0] low_cnt_reg;   // consecutive low cycles before this one
  logic          fault_reg;     // pin stuck low in slave mode

  if (FAULT_CYC <= fnrc_pkg::RESET_TRIG_CYC)
  begin : g_chk
    $error("fault limit must lie beyond the trigger point");
  end

  // counted on the system clock, saturating so it never wraps [R16]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      low_cnt_reg <= '0;
    else if (ext_reset_n)
      low_cnt_reg <= '0;
    else if (low_cnt_reg != CW'(FAULT_CYC))
      low_cnt_reg <= low_cnt_reg + 1'b1;
  end

  // one pulse per low phase; later level has no effect [R12] [R10]
  assign trig = !ext_reset_n && (low_cnt_reg == CW'(fnrc_pkg::RESET_TRIG_CYC - 1));

  // stuck-low detection, only meaningful as a slave [R13]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fault_reg <= 1'b0;
    else
      fault_reg <= slave_mode && !ext_reset_n && (low_cnt_reg >= CW'(FAULT_CYC - 1));
  end

  assign fault = fault_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_reject;                    // [R10]
    !ext_reset_n && (low_cnt_reg < CW'(fnrc_pkg::RESET_REJECT_CYC)) |-> !trig;
  endproperty
  a_reject: assert property (p_reject) else $error("short low pulse triggered reset");

  property p_once;                      // [R12]
    trig |=> !trig [*2];
  endproperty
  a_once: assert property (p_once) else $error("reset triggered twice");

  property p_fault_cause;               // [R13]
    $rose(fault_reg) |-> $past(slave_mode) && $past(!ext_reset_n, 2);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without stuck pin");

endmodule

// ### fnrc_reset_ctrl.sv
// reset sequencer of a field-bus node: power-on, logic and pin resets
// assumes synchronous inputs and a plain register port driven on clk
//
// Behaviour
// R1: any reset loads 0xF, outputs go hi-z
// R2: non power-on resets pulse both strobes together
// R3: lock set in reset, data refused until parameters
// R4: master writes parameters before first data exchange
// R5: command or pin reset initializes within 2 ms
// R6: power-up init within 30 ms, 1000 ms loaded
// R7: power-on pulse lasts 4 to 6 us
// R8: commands, watchdog, illegal state fully reset chip
// R9: pin reset works in every mode
// R10: pin low up to 35 us ignored
// R11: pin low gives hi-z within 44 us
// R12: pin reset fires once, init starts at once
// R13: slave flags fault if pin stays low
// R14: init after pin reset reads config memory
// R15: fault shows its own indicator pattern
// R16: low time counted on system clock
module fnrc_reset_ctrl #(
  parameter int INIT_CYC       = fnrc_pkg::INIT_CYC,
  parameter int INIT2_CYC      = fnrc_pkg::INIT2_CYC,
  parameter int INIT3_CYC      = fnrc_pkg::INIT3_CYC,
  parameter int FAULT_CYC      = fnrc_pkg::FAULT_CYC,
  parameter int FLASH_HALF_CYC = fnrc_pkg::FLASH_HALF_CYC,
  parameter int CFG_WORDS      = 4
)(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire fnrc_pkg::fnrc_bus_t    bus_req,
  output logic [31:0]                 bus_rdata,
  input  wire fnrc_pkg::fnrc_mode_t   op_mode,
  input  wire logic                   supply_low,
  input  wire logic                   slave_reset_cmd,
  input  wire logic                   bcast_reset_cmd,
  input  wire logic                   wdog_expired,
  input  wire logic                   illegal_state,
  input  wire logic                   ext_reset_n,
  input  wire logic                   data_wr_req,
  input  wire logic [3:0]             data_wr_val,
  input  wire logic                   param_wr_req,
  input  wire logic [3:0]             param_wr_val,
  output logic [3:0]                  data_out_pins,
  output logic [3:0]                  data_out_pins_oe_n,
  output logic [3:0]                  param_out_pins,
  output logic [3:0]                  param_out_pins_oe_n,
  output logic                        data_strobe,
  output logic                        param_strobe,
  output logic                        dx_lock,
  output logic                        chip_reset,
  output logic                        init_busy,
  output logic                        cfg_rd_req,
  output logic [$clog2(CFG_WORDS)-1:0] cfg_rd_addr,
  input  wire logic                   cfg_rd_ack,
  input  wire logic [7:0]             cfg_rd_data,
  output logic [8*CFG_WORDS-1:0]      cfg_image,
  output logic                        serious_fault,
  output logic                        led_green,
  output logic                        led_red,
  output logic                        irq
);

  localparam int TW = fnrc_pkg::TMR_W;
  localparam int AW = $clog2(CFG_WORDS);
  localparam int FW = $clog2(FLASH_HALF_CYC + 1);

  if (CFG_WORDS < 2 || CFG_WORDS > 64 || INIT_CYC <= CFG_WORDS || INIT3_CYC >= 2 ** TW)
  begin : g_chk
    $error("unsupported config size or init limit");
  end

  fnrc_pkg::fnrc_state_t state_reg;      // sequencer state
  logic [TW-1:0]         tmr_reg;        // time in current state
  logic                  por_kind_reg;   // current reset came from power
  logic [3:0]            data_out_reg;   // data output value
  logic [3:0]            param_out_reg;  // parameter output value
  logic [3:0]            data_oe_n_reg;  // data drivers off when high
  logic [3:0]            param_oe_n_reg; // parameter drivers off when high
  logic                  data_stb_reg;   // data strobe pulse
  logic                  param_stb_reg;  // parameter strobe pulse
  logic                  lock_reg;       // data exchange lock
  logic [AW-1:0]         cfg_idx_reg;    // next config word
  logic                  cfg_done_reg;   // config readout complete
  logic [7:0]            cfg_mem [CFG_WORDS];
  logic [1:0]            ctrl_reg;       // watchdog enable, heavy load
  logic [7:0]            mask_reg;       // interrupt mask
  fnrc_pkg::fnrc_evt_t   stat_reg;       // sticky events
  logic [31:0]           rdata_reg;      // read data, one cycle late
  logic                  fault_d_reg;    // fault, one cycle old
  logic [FW-1:0]         flash_cnt_reg;  // flash divider
  logic                  flash_ph_reg;   // flash phase
  logic                  led_g_reg;
  logic                  led_r_reg;

  logic                  ext_trig;       // pin reset fires
  logic                  pin_fault;      // pin stuck low
  logic                  wdog_hit;       // enabled watchdog expiry
  logic                  entering_rst;   // logic reset starts now
  logic                  data_acc;       // data write taken
  logic                  param_acc;      // parameter write taken
  logic [TW-1:0]         init_limit;     // budget of this init
  fnrc_pkg::fnrc_evt_t   evt;            // events of this cycle

  // pin timer; runs whatever the operating mode is [R9]
  fnrc_pin_timer #(
    .FAULT_CYC   (FAULT_CYC)
  ) u_pin (
    .clk         (clk),
    .rstn        (rstn),
    .ext_reset_n (ext_reset_n),
    .slave_mode  (op_mode == fnrc_pkg::MODE_SLAVE),
    .trig        (ext_trig),
    .fault       (pin_fault)
  );

  // reset causes; a power-on reset already covers all of them [R8]
  assign wdog_hit     = wdog_expired && ctrl_reg[fnrc_pkg::CTRL_WDOG_EN_BIT];
  assign entering_rst = !supply_low && (state_reg != fnrc_pkg::ST_POR) &&
                        (slave_reset_cmd || bcast_reset_cmd || wdog_hit || illegal_state || ext_trig);

  // data writes wait for the lock to drop [R3] [R4]
  assign data_acc  = data_wr_req && (state_reg == fnrc_pkg::ST_RUN) && !lock_reg &&
                     !supply_low && !entering_rst;
  assign param_acc = param_wr_req && (state_reg == fnrc_pkg::ST_RUN) && !supply_low && !entering_rst;

  // init budget depends on what caused the reset [R5] [R6]
  always_comb
  begin
    if (!por_kind_reg)
      init_limit = TW'(INIT_CYC);
    else if (ctrl_reg[fnrc_pkg::CTRL_BIGCAP_BIT])
      init_limit = TW'(INIT3_CYC);
    else
      init_limit = TW'(INIT2_CYC);
  end

  // sequencer; supply drop wins over every other cause
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg    <= fnrc_pkg::ST_POR;
      tmr_reg      <= '0;
      por_kind_reg <= 1'b1;
    end
    else if (supply_low)
    begin
      state_reg    <= fnrc_pkg::ST_POR;
      tmr_reg      <= '0;
      por_kind_reg <= 1'b1;
    end
    else if (entering_rst)
    begin
      state_reg    <= fnrc_pkg::ST_RST;   // [R8] [R12]
      tmr_reg      <= '0;
      por_kind_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        fnrc_pkg::ST_POR:
          // fixed-width internal pulse after supply is good [R7]
          if (tmr_reg == TW'(fnrc_pkg::POR_PULSE_CYC - 1))
          begin
            state_reg <= fnrc_pkg::ST_INIT;
            tmr_reg   <= '0;
          end
          else
            tmr_reg <= tmr_reg + 1'b1;
        fnrc_pkg::ST_RST:
          // short chip reset, then init at once [R12]
          if (tmr_reg == TW'(fnrc_pkg::RESET_HOLD_CYC - 1))
          begin
            state_reg <= fnrc_pkg::ST_INIT;
            tmr_reg   <= '0;
          end
          else
            tmr_reg <= tmr_reg + 1'b1;
        fnrc_pkg::ST_INIT:
          // a silent config memory cannot stall init past its budget [R5] [R6] [R14]
          if (cfg_done_reg || tmr_reg == init_limit - 1'b1)
          begin
            state_reg <= fnrc_pkg::ST_RUN;
            tmr_reg   <= '0;
          end
          else
            tmr_reg <= tmr_reg + 1'b1;
        fnrc_pkg::ST_RUN:
          tmr_reg <= '0;
      endcase
    end
  end

  // config memory readout during init [R14]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_idx_reg  <= '0;
      cfg_done_reg <= 1'b0;
      for (int i = 0; i < CFG_WORDS; i++)
        cfg_mem[i] <= 8'h00;
    end
    else if (state_reg != fnrc_pkg::ST_INIT)
    begin
      cfg_idx_reg  <= '0;
      cfg_done_reg <= 1'b0;
    end
    else if (cfg_rd_req && cfg_rd_ack)
    begin
      cfg_mem[cfg_idx_reg] <= cfg_rd_data;
      if (cfg_idx_reg == AW'(CFG_WORDS - 1))
        cfg_done_reg <= 1'b1;
      else
        cfg_idx_reg <= cfg_idx_reg + 1'b1;
    end
  end

  // outputs to 0xF and hi-z on every reset [R1] [R11]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_out_reg   <= fnrc_pkg::OUT_RESET_VAL;
      param_out_reg  <= fnrc_pkg::OUT_RESET_VAL;
      data_oe_n_reg  <= 4'hF;
      param_oe_n_reg <= 4'hF;
    end
    else if (supply_low || entering_rst)
    begin
      data_out_reg   <= fnrc_pkg::OUT_RESET_VAL;
      param_out_reg  <= fnrc_pkg::OUT_RESET_VAL;
      data_oe_n_reg  <= 4'hF;
      param_oe_n_reg <= 4'hF;
    end
    else
    begin
      // drivers come back only with the first write after init
      if (data_acc)
      begin
        data_out_reg  <= data_wr_val;
        data_oe_n_reg <= 4'h0;
      end
      if (param_acc)
      begin
        param_out_reg  <= param_wr_val;
        param_oe_n_reg <= 4'h0;
      end
    end
  end

  // strobes: both together on logic resets, never on power-on [R2]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_stb_reg  <= 1'b0;
      param_stb_reg <= 1'b0;
    end
    else
    begin
      data_stb_reg  <= entering_rst || data_acc;
      param_stb_reg <= entering_rst || param_acc;
    end
  end

  // lock: set by any reset, cleared by a parameter write; set wins [R3]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lock_reg <= 1'b1;
    else if (supply_low || entering_rst || state_reg != fnrc_pkg::ST_RUN)
      lock_reg <= 1'b1;
    else if (param_acc)
      lock_reg <= 1'b0;
  end

  // events of this cycle
  always_comb
  begin
    evt         = '0;
    evt.ext     = ext_trig;
    evt.cmd     = slave_reset_cmd;
    evt.bcast   = bcast_reset_cmd;
    evt.wdog    = wdog_hit;
    evt.illegal = illegal_state;
    evt.por     = (state_reg == fnrc_pkg::ST_POR) && !supply_low &&
                  (tmr_reg == TW'(fnrc_pkg::POR_PULSE_CYC - 1));
    evt.refused = data_wr_req && !data_acc;
    evt.fault   = pin_fault && !fault_d_reg;
  end

  // register writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= fnrc_pkg::CTRL_RESET_VAL;
      mask_reg <= fnrc_pkg::MASK_RESET_VAL;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == fnrc_pkg::REG_CTRL)
        ctrl_reg <= bus_req.wdata[1:0];
      if (bus_req.addr == fnrc_pkg::REG_MASK)
        mask_reg <= bus_req.wdata[7:0];
    end
  end

  // sticky status, cleared by reading it; a same-cycle event survives
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stat_reg <= '0;
    else if (bus_req.rd && bus_req.addr == fnrc_pkg::REG_STAT)
      stat_reg <= evt;
    else
      stat_reg <= stat_reg | evt;
  end

  // read data stands one cycle only; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= 32'h0;
    else if (!bus_req.rd)
      rdata_reg <= 32'h0;
    else
    begin
      unique case (bus_req.addr)
        fnrc_pkg::REG_CTRL:  rdata_reg <= {30'h0, ctrl_reg};
        fnrc_pkg::REG_STAT:  rdata_reg <= {24'h0, stat_reg};
        fnrc_pkg::REG_MASK:  rdata_reg <= {24'h0, mask_reg};
        fnrc_pkg::REG_STATE: rdata_reg <= {24'h0, cfg_done_reg, pin_fault, lock_reg,
                                           1'b0, op_mode, state_reg};
        default:             rdata_reg <= 32'h0;
      endcase
    end
  end

  // flash divider, one phase toggle per half period
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= 1'b0;
    end
    else if (flash_cnt_reg == FW'(FLASH_HALF_CYC - 1))
    begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= !flash_ph_reg;
    end
    else
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
  end

  // indicator: fault alternates, lock is red, unlocked is green [R15]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_d_reg <= 1'b0;
      led_g_reg   <= 1'b0;
      led_r_reg   <= 1'b1;
    end
    else
    begin
      fault_d_reg <= pin_fault;
      if (pin_fault)
      begin
        led_g_reg <= flash_ph_reg;
        led_r_reg <= !flash_ph_reg;
      end
      else
      begin
        led_g_reg <= !lock_reg;
        led_r_reg <= lock_reg;
      end
    end
  end

  assign bus_rdata           = rdata_reg;
  assign data_out_pins       = data_out_reg;
  assign data_out_pins_oe_n  = data_oe_n_reg;
  assign param_out_pins      = param_out_reg;
  assign param_out_pins_oe_n = param_oe_n_reg;
  assign data_strobe         = data_stb_reg;
  assign param_strobe        = param_stb_reg;
  assign dx_lock             = lock_reg;
  assign chip_reset          = (state_reg == fnrc_pkg::ST_POR) || (state_reg == fnrc_pkg::ST_RST);
  assign init_busy           = (state_reg == fnrc_pkg::ST_INIT);
  assign cfg_rd_req          = init_busy && !cfg_done_reg;
  assign cfg_rd_addr         = cfg_idx_reg;
  assign serious_fault       = pin_fault;
  assign led_green           = led_g_reg;
  assign led_red             = led_r_reg;
  assign irq                 = |(stat_reg & mask_reg);

  for (genvar g = 0; g < CFG_WORDS; g++)
  begin : g_img
    assign cfg_image[8*g +: 8] = cfg_mem[g];
  end

  // helper counters read only by the checks below
  logic [TW-1:0] por_len_reg;
  logic [TW-1:0] init_len_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      por_len_reg  <= '0;
      init_len_reg <= '0;
    end
    else
    begin
      por_len_reg  <= (state_reg == fnrc_pkg::ST_POR && !supply_low) ? por_len_reg + 1'b1 : '0;
      init_len_reg <= (state_reg == fnrc_pkg::ST_INIT) ? init_len_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rst_entry;
    state_reg == fnrc_pkg::ST_RUN ##1 state_reg == fnrc_pkg::ST_RST;
  endsequence

  property p_reset_outputs;             // [R1]
    chip_reset |-> data_out_reg == 4'hF && param_out_reg == 4'hF && &data_oe_n_reg && &param_oe_n_reg;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not parked in reset");

  property p_strobe_pair;               // [R2]
    s_rst_entry |-> data_stb_reg && param_stb_reg;
  endproperty
  a_strobe_pair: assert property (p_strobe_pair) else $error("strobes missing on logic reset");

  property p_por_quiet;                 // [R2]
    state_reg == fnrc_pkg::ST_POR |-> !data_stb_reg && !param_stb_reg;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("strobe during power-on reset");

  property p_lock_refuse;               // [R3]
    data_wr_req && lock_reg && !supply_low && !entering_rst |=> !data_stb_reg && $stable(data_out_reg);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("data taken while locked");

  property p_por_width;                 // [R7]
    $fell(state_reg == fnrc_pkg::ST_POR) |->
      por_len_reg >= TW'(fnrc_pkg::POR_MIN_CYC) && por_len_reg <= TW'(fnrc_pkg::POR_MAX_CYC);
  endproperty
  a_por_width: assert property (p_por_width) else $error("power-on pulse out of range");

  property p_init_bound;                // [R5] [R6] [R14]
    state_reg == fnrc_pkg::ST_INIT |-> init_len_reg < init_limit && lock_reg;
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init overran its budget");

  property p_cause;                     // [R8]
    (slave_reset_cmd || bcast_reset_cmd || illegal_state) && state_reg == fnrc_pkg::ST_RUN && !supply_low
      |=> state_reg == fnrc_pkg::ST_RST ##2 state_reg == fnrc_pkg::ST_INIT;
  endproperty
  a_cause: assert property (p_cause) else $error("reset command not executed");

  property p_ext_hiz;                   // [R11] [R12]
    ext_trig && !supply_low |=> state_reg == fnrc_pkg::ST_RST && &data_oe_n_reg && &param_oe_n_reg;
  endproperty
  a_ext_hiz: assert property (p_ext_hiz) else $error("pin reset did not park drivers");

  property p_fault_led;                 // [R15]
    pin_fault [*2] |-> led_g_reg != led_r_reg && led_g_reg == $past(flash_ph_reg);
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("fault pattern not shown");

endmodule

// ### fnrc_cfg_model.sv
// config memory model answering the sequencer's word readout
// assumes one clock; acks in the same cycle as the request
module fnrc_cfg_model (
  input  wire logic       clk,
  input  wire logic       cfg_rd_req,
  input  wire logic [1:0] cfg_rd_addr,
  output logic            cfg_rd_ack,
  output logic [7:0]      cfg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk_reg = 8'h5A; // idle filler
  // idle bus keeps moving so a stale word is never mistaken for data
  always_ff @(posedge clk)
    junk_reg <= junk_reg + 8'h37;
  assign cfg_rd_ack  = cfg_rd_req; // prompt answer
  assign cfg_rd_data = cfg_rd_req ? {6'h2C, cfg_rd_addr} : junk_reg;
endmodule

// ### test_fnrc_reset_ctrl.sv
// self-checking bench of the reset sequencer
// assumes 100 MHz clk, shortened init and fault counts
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t %0h %0h", $time, a, e); end end
module test_fnrc_reset_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, ext_n = 1, dreq = 0, preq = 0, sup = 0; // stimulus
  logic [3:0] cause = 4'h0, dval = 4'h0, pval = 4'h0; // causes: illegal,wdog,bcast,slave
  fnrc_pkg::fnrc_bus_t bus = '0; // register port request
  fnrc_pkg::fnrc_mode_t mode = fnrc_pkg::MODE_SLAVE; // operating mode
  logic [31:0] rdata, img; // read data, config image
  logic [3:0] dpin, doe, ppin, poe; // output pins and enables
  logic dstb, pstb, lock, crst, busy, creq, cack, sfault, irq, lg, lr, lg0;
  logic [1:0] caddr;
  logic [7:0] cdata;
  int errors = 0, checks = 0, n;
  logic [7:0] rows [4] = '{8'h50, 8'hA3, 8'h0F, 8'hF0}; // {param, data}
  fnrc_reset_ctrl #(.INIT_CYC(40), .INIT2_CYC(60), .INIT3_CYC(80), .FAULT_CYC(4100), .FLASH_HALF_CYC(8)) DUT (
    .clk(clk), .rstn(rstn), .bus_req(bus), .bus_rdata(rdata), .op_mode(mode), .supply_low(sup),
    .slave_reset_cmd(cause[0]), .bcast_reset_cmd(cause[1]), .wdog_expired(cause[2]),
    .illegal_state(cause[3]), .ext_reset_n(ext_n), .data_wr_req(dreq), .data_wr_val(dval),
    .param_wr_req(preq), .param_wr_val(pval), .data_out_pins(dpin), .data_out_pins_oe_n(doe),
    .param_out_pins(ppin), .param_out_pins_oe_n(poe), .data_strobe(dstb), .param_strobe(pstb),
    .dx_lock(lock), .chip_reset(crst), .init_busy(busy), .cfg_rd_req(creq), .cfg_rd_addr(caddr),
    .cfg_rd_ack(cack), .cfg_rd_data(cdata), .cfg_image(img), .serious_fault(sfault),
    .led_green(lg), .led_red(lr), .irq(irq));
  fnrc_cfg_model MEM (.clk(clk), .cfg_rd_req(creq), .cfg_rd_addr(caddr), .cfg_rd_ack(cack),
    .cfg_rd_data(cdata));
  // free-running 100 MHz clock
  initial
    forever #5 clk = ~clk;
  task conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one-cycle register write and read
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 `CHK(rdata, e)
  endtask
  // parameter and data writes, sampled one cycle on
  task pw(input logic [3:0] v);
    @(posedge clk) {preq, pval} <= {1'b1, v};
    @(posedge clk) preq <= 1'b0;
    #1;
  endtask
  task dw(input logic [3:0] v);
    @(posedge clk) {dreq, dval} <= {1'b1, v};
    @(posedge clk) dreq <= 1'b0;
    #1;
  endtask
  // bounded wait for run state, then drive outputs again
  task restore(input logic [3:0] p);
    n = 0;
    while ((crst | busy) !== 1'b0 && n < 800)
    begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n < 800, 1'b1)
    pw(p);
    dw(~p);
  endtask
  // hang guard, well past the expected run length
  initial
  begin
    #1000000 errors++;
    conclude;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    `CHK({doe, poe, dpin, lock}, 13'h1FFF)
    rstn <= 1'b1;
    restore(4'h0);
    `CHK(img, 32'hB3B2B1B0)
    wr(8'h08, 32'h40);
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    restore(4'h1);
    wr(8'h08, 32'h40);
    rd(8'h04, 32'h20);
    // locked data write is refused and raises the interrupt
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    repeat (520) @(posedge clk);
    wr(8'h08, 32'h40);
    dw(4'h9);
    `CHK({doe, irq}, 5'h1F)
    rd(8'h04, 32'h60);
    `CHK(irq, 1'b0)
    foreach (rows[i])
    begin
      pw(rows[i][7:4]);
      `CHK({ppin, poe, pstb, lock}, {rows[i][7:4], 4'h0, 2'b10})
      dw(rows[i][3:0]);
      `CHK({dpin, doe, dstb}, {rows[i][3:0], 4'h0, 1'b1})
    end
    wr(8'h00, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) cause <= 4'h1 << i;
      @(posedge clk) cause <= 4'h0;
      #1 `CHK({crst, dstb, pstb, lock, dpin, ppin, doe, poe}, 20'hFFFFF)
      restore(4'h6);
    end
    rd(8'h04, 32'h1E);
    @(posedge clk) ext_n <= 1'b0;
    repeat (3500) @(posedge clk);
    ext_n <= 1'b1;
    #1 `CHK({crst, doe}, 5'h0)
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge clk) mode <= m ? fnrc_pkg::MODE_MASTER : fnrc_pkg::MODE_SLAVE;
      ext_n <= 1'b0;
      #1 n = 0;
      while (doe !== 4'hF && n < 5000)
      begin
        @(posedge clk);
        #1 n++;
      end
      `CHK(n > 3500 && n <= 4400, 1'b1)
      while (sfault !== 1'b1 && n < 4200)
      begin
        @(posedge clk);
        #1 n++;
      end
      `CHK({sfault, m == 0 ? n < 4104 : 1'b1}, {m == 0, 1'b1})
      // fault pattern must flip once per flash half period
      if (m == 0)
      begin
        repeat (2) @(posedge clk);
        #1 lg0 = lg;
        repeat (8) @(posedge clk);
        #1 `CHK({lg, lr}, {~lg0, lg0})
      end
      restore(4'h3);
      @(posedge clk) ext_n <= 1'b1;
    end
    // supply drop: parked outputs, lock set, but no strobes
    @(posedge clk) sup <= 1'b1;
    @(posedge clk) sup <= 1'b0;
    #1 `CHK({crst, dstb, pstb, lock, doe, poe}, 12'h9FF)
    restore(4'h5);
    conclude;
  end
endmodule
